// File: input_remap_pkg.sv
// What this block does
// - upper selector bits 14:8, lower 6:0
// - code zero ties input to ground
// - code one routes comparator one output
// - all ones code routes pin 127
// - bits 15 and 7 read zero
// - single selector: bits 15:7 read zero
// - selectors read/write, cleared at reset
// - encoder two selectors only on motor variants
// - first uart receive and cts routed
// - second uart receive and cts routed
// - first spi clock and data routed
// - both spi slave selects routed
// - converter interface clock and data routed
// - encoder two home and index routed
package input_remap_pkg;
    localparam int SEL_W = 7;
    localparam int ADDR_W = 4;
    localparam int NUM_REGS = 7;
    localparam int NUM_SEL = 12;
    localparam logic [ADDR_W-1:0] ENCODER2_SEL_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] UART1_SEL_OFFSET = 4'h1;
    localparam logic [ADDR_W-1:0] UART2_SEL_OFFSET = 4'h2;
    localparam logic [ADDR_W-1:0] SPI1_CLK_DATA_SEL_OFFSET = 4'h3;
    localparam logic [ADDR_W-1:0] SPI1_SELECT_SEL_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] SPI2_SELECT_SEL_OFFSET = 4'h5;
    localparam logic [ADDR_W-1:0] CONVERTER_SEL_OFFSET = 4'h6;
    localparam int UPPER_LSB = 8;
    localparam int LOWER_LSB = 0;
    localparam logic [SEL_W-1:0] SEL_RESET = 7'h00;
    localparam logic [SEL_W-1:0] SEL_GROUND = 7'h00;
    localparam logic [SEL_W-1:0] SEL_COMPARATOR = 7'h01;
    localparam int SYNC_STAGES = 2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic encoder2Home;
        logic encoder2Index;
        logic uart1Rx;
        logic uart1CtsN;
        logic uart2Rx;
        logic uart2CtsN;
        logic spi1Clock;
        logic spi1DataIn;
        logic spi1SelectN;
        logic spi2SelectN;
        logic converterClock;
        logic converterData;
    } periph_in_s;
endpackage : input_remap_pkg

// File: pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 128
) (
    input wire logic clk,
    input wire logic rstN,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    import input_remap_pkg::*;
    logic [WIDTH-1:0] meta_q;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            meta_q <= '0;
            synced <= '0;
        end
        else
        begin
            meta_q <= async;
            synced <= meta_q;
        end
    end
endmodule : pin_sync

// File: source_select.sv
`timescale 1ns/10ps
module source_select #(
    parameter int PINS = 128
) (
    input wire logic [input_remap_pkg::SEL_W-1:0] code,
    input wire logic [PINS-1:0] pins,
    input wire logic comparatorOne,
    output logic routed
);
    import input_remap_pkg::*;
    // pins index 0 and 1 never reach the output: those codes are ground and comparator
    assign routed = (code == SEL_GROUND) ? 1'b0 :
                    (code == SEL_COMPARATOR) ? comparatorOne :
                    pins[code];
endmodule : source_select

// File: input_pin_remap_selectors.sv
`timescale 1ns/10ps
module input_pin_remap_selectors #(
    parameter bit MOTOR_VARIANT = 1'b1,
    parameter int PINS = 128
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire input_remap_pkg::reg_req_s regReq,
    output logic [15:0] regRdata,
    input wire logic [PINS-1:0] remappablePins,
    input wire logic comparatorOneOutput,
    output input_remap_pkg::periph_in_s periphIn
);
    import input_remap_pkg::*;

    logic rstSync1_q;
    logic rstN_q;
    logic [SEL_W-1:0] sel_q [NUM_SEL];
    logic [SEL_W-1:0] sel_d [NUM_SEL];
    logic [PINS-1:0] pinsSync;
    logic cmpMeta_q;
    logic cmpSync_q;
    logic [NUM_SEL-1:0] routed;
    logic [15:0] readValue;
    logic [15:0] rdata_q;
    periph_in_s periph_q;

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rstSync1_q <= 1'b0;
            rstN_q <= 1'b0;
        end
        else
        begin
            rstSync1_q <= 1'b1;
            rstN_q <= rstSync1_q;
        end
    end

    pin_sync #(.WIDTH(PINS)) u_pin_sync (
        .clk(mclk),
        .rstN(rstN_q),
        .async(remappablePins),
        .synced(pinsSync)
    );

    always_ff @(posedge mclk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            cmpMeta_q <= 1'b0;
            cmpSync_q <= 1'b0;
        end
        else
        begin
            cmpMeta_q <= comparatorOneOutput;
            cmpSync_q <= cmpMeta_q;
        end
    end

    // selector index 0-7: even = upper field, odd = lower field of register i/2; 8 and 9 = lower fields of registers 4 and 5, 10 and 11 = register 6
    function automatic logic hasUpper(input logic [ADDR_W-1:0] a);
        return !(a == SPI1_SELECT_SEL_OFFSET || a == SPI2_SELECT_SEL_OFFSET);
    endfunction : hasUpper

    function automatic logic implemented(input logic [ADDR_W-1:0] a);
        return (a < ADDR_W'(NUM_REGS)) && (MOTOR_VARIANT || a != ENCODER2_SEL_OFFSET);
    endfunction : implemented

    wire writeHit = regReq.wr && implemented(regReq.addr);
    wire [SEL_W-1:0] upperWrite = regReq.wdata[UPPER_LSB +: SEL_W];
    wire [SEL_W-1:0] lowerWrite = regReq.wdata[LOWER_LSB +: SEL_W];

    always_comb
    begin
        for (int i = 0; i < NUM_SEL; i++)
        begin
            sel_d[i] = sel_q[i];
        end
        if (writeHit)
        begin
            // bits 15 and 7 are simply not stored
            for (int r = 0; r < NUM_REGS; r++)
            begin
                if (regReq.addr == ADDR_W'(r))
                begin
                    if (r == int'(SPI1_SELECT_SEL_OFFSET))
                    begin
                        sel_d[8] = lowerWrite;
                    end
                    else if (r == int'(SPI2_SELECT_SEL_OFFSET))
                    begin
                        sel_d[9] = lowerWrite;
                    end
                    else if (r == int'(CONVERTER_SEL_OFFSET))
                    begin
                        sel_d[10] = upperWrite;
                        sel_d[11] = lowerWrite;
                    end
                    else
                    begin
                        sel_d[2*r] = upperWrite;
                        sel_d[2*r+1] = lowerWrite;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            for (int i = 0; i < NUM_SEL; i++)
            begin
                sel_q[i] <= SEL_RESET;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_SEL; i++)
            begin
                sel_q[i] <= sel_d[i];
            end
        end
    end

    // register layout index per address
    wire [3:0] upIdx = (regReq.addr == CONVERTER_SEL_OFFSET) ? 4'ha :
                       4'((regReq.addr << 1));
    wire [3:0] loIdx = (regReq.addr == SPI1_SELECT_SEL_OFFSET) ? 4'h8 :
                       (regReq.addr == SPI2_SELECT_SEL_OFFSET) ? 4'h9 :
                       (regReq.addr == CONVERTER_SEL_OFFSET) ? 4'hb :
                       4'((regReq.addr << 1) | 4'h1);
    wire [SEL_W-1:0] upRead = hasUpper(regReq.addr) ? sel_q[upIdx] : SEL_RESET;
    assign readValue = implemented(regReq.addr) ?
                       {1'b0, upRead, 1'b0, sel_q[loIdx]} : 16'h0000;

    always_ff @(posedge mclk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            rdata_q <= 16'h0000;
        end
        else if (regReq.rd)
        begin
            rdata_q <= readValue;
        end
        else
        begin
            rdata_q <= 16'h0000;
        end
    end
    assign regRdata = rdata_q;

    for (genvar g = 0; g < NUM_SEL; g++)
    begin : g_route
        source_select #(.PINS(PINS)) u_sel (
            .code(sel_q[g]),
            .pins(pinsSync),
            .comparatorOne(cmpSync_q),
            .routed(routed[g])
        );
    end

    // registered so every output leaves a flop; selection lands one cycle after the write
    always_ff @(posedge mclk or negedge rstN_q)
    begin
        if (!rstN_q)
        begin
            periph_q <= '0;
        end
        else
        begin
            periph_q.encoder2Home <= MOTOR_VARIANT & routed[0];
            periph_q.encoder2Index <= MOTOR_VARIANT & routed[1];
            periph_q.uart1CtsN <= routed[2];
            periph_q.uart1Rx <= routed[3];
            periph_q.uart2CtsN <= routed[4];
            periph_q.uart2Rx <= routed[5];
            periph_q.spi1Clock <= routed[6];
            periph_q.spi1DataIn <= routed[7];
            periph_q.spi1SelectN <= routed[8];
            periph_q.spi2SelectN <= routed[9];
            periph_q.converterClock <= routed[10];
            periph_q.converterData <= routed[11];
        end
    end
    assign periphIn = periph_q;
endmodule : input_pin_remap_selectors

// File: input_pin_remap_selectors_assertions.sv
`timescale 1ns/10ps
module remap_checker
    import input_remap_pkg::*;
#(
    parameter int PINS = 128
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire input_remap_pkg::reg_req_s regReq,
    input wire logic [15:0] regRdata,
    input wire logic [PINS-1:0] remappablePins,
    input wire logic comparatorOneOutput,
    input wire input_remap_pkg::periph_in_s periphIn
);
    // pin history lines up with the two sync flops plus the route register
    logic [PINS-1:0] pin1Q, pin2Q, pin3Q;
    always_ff @(posedge mclk)
    begin
        pin1Q <= remappablePins;
        pin2Q <= pin1Q;
        pin3Q <= pin2Q;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_reset_clears: assert property (disable iff (1'b0)
        !nrst |-> periphIn == '0 && regRdata == 16'h0000) else $error("outputs not clear in reset");
    a_unused_bits_zero: assert property (regRdata[15] == 1'b0 && regRdata[7] == 1'b0)
        else $error("unimplemented bit reads one");
    a_single_upper_zero: assert property (
        $past(regReq.rd && regReq.addr inside {4'h4, 4'h5}) |-> regRdata[15:8] == 8'h00)
        else $error("single selector upper byte not zero");
    a_ground_route: assert property (
        $past(regReq.wr && regReq.addr == 4'h5 && regReq.wdata[6:0] == 7'h00, 2)
        |-> !periphIn.spi2SelectN) else $error("code zero not ground");
    a_comparator_route: assert property (
        $past(regReq.wr && regReq.addr == 4'h3 && regReq.wdata[6:0] == 7'h01, 2)
        |-> periphIn.spi1DataIn == $past(comparatorOneOutput, 3)) else $error("comparator not routed");
    a_top_pin_route: assert property (
        $past(regReq.wr && regReq.addr == 4'h3 && regReq.wdata[14:8] == 7'h7f, 2)
        |-> periphIn.spi1Clock == pin3Q[127]) else $error("pin 127 not routed");
    a_lower_pin_route: assert property (
        $past(regReq.wr && regReq.addr == 4'h6 && regReq.wdata[6:0] > 7'h01, 2)
        |-> periphIn.converterData == pin3Q[$past(regReq.wdata[6:0], 2)])
        else $error("lower field pin not routed");
    a_upper_pin_route: assert property (
        $past(regReq.wr && regReq.addr == 4'h1 && regReq.wdata[14:8] > 7'h01, 2)
        |-> periphIn.uart1CtsN == pin3Q[$past(regReq.wdata[14:8], 2)])
        else $error("upper field pin not routed");
endmodule : remap_checker

bind input_pin_remap_selectors remap_checker #(.PINS(PINS)) remap_checker_inst (.mclk(mclk),
    .nrst(nrst), .regReq(regReq), .regRdata(regRdata), .remappablePins(remappablePins),
    .comparatorOneOutput(comparatorOneOutput), .periphIn(periphIn));

// File: input_pin_remap_selectors_tb_top.sv
`timescale 1ns/10ps
module input_pin_remap_selectors_tb_top;
    import input_remap_pkg::*;
    logic mclk = 1'b0;
    // starts high so the first drive low is a real falling edge for the async reset
    logic nrst = 1'b1;
    reg_req_s regReq = '0;
    logic [15:0] regRdata;
    logic [127:0] pins = '0;
    logic cmp = 1'b0;
    periph_in_s periphIn;
    logic [15:0] basicRdata;
    periph_in_s basicPeriphIn;
    int n_fail = 0;
    int n_tests = 0;

    always #5 mclk = ~mclk;

    input_pin_remap_selectors input_pin_remap_selectors_inst (.mclk(mclk), .nrst(nrst),
        .regReq(regReq), .regRdata(regRdata), .remappablePins(pins),
        .comparatorOneOutput(cmp), .periphIn(periphIn));

    // variant without the encoder two selectors, fed the same stimulus
    input_pin_remap_selectors #(.MOTOR_VARIANT(1'b0)) input_pin_remap_selectors_basic_inst (
        .mclk(mclk),
        .nrst(nrst),
        .regReq(regReq),
        .regRdata(basicRdata),
        .remappablePins(pins),
        .comparatorOneOutput(cmp),
        .periphIn(basicPeriphIn)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq.wr <= 1'b0;
    endtask : write_reg

    task automatic read_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        regReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq.rd <= 1'b0;
        #1 check(regRdata, exp);
        check(basicRdata, (a == ENCODER2_SEL_OFFSET) ? 16'h0000 : exp);
    endtask : read_reg

    task automatic do_reset;
        nrst <= 1'b0;
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : do_reset

    task automatic t_zero;
        for (int i = 0; i < 7; i++) read_reg(i[3:0], 16'h0000);
        check({4'h0, periphIn}, 16'h0000);
        check({4'h0, basicPeriphIn}, 16'h0000);
    endtask : t_zero

    task automatic t_fields;
        for (int i = 0; i < 7; i++) write_reg(i[3:0], 16'hffff);
        for (int i = 0; i < 7; i++) read_reg(i[3:0], (i == 4 || i == 5) ? 16'h007f : 16'h7f7f);
        write_reg(4'h7, 16'h1234);
        read_reg(4'h7, 16'h0000);
        read_reg(4'hf, 16'h0000);
    endtask : t_fields

    task automatic t_route;
        logic [127:0] pat [3] = '{{128{1'b1}}, {64{2'b10}}, {64{2'b01}}};
        logic [127:0] p;
        logic [15:0] e;
        write_reg(4'h0, 16'h0203);
        write_reg(4'h1, 16'h0405);
        write_reg(4'h2, 16'h0607);
        write_reg(4'h3, 16'h7f01);
        write_reg(4'h4, 16'h0008);
        write_reg(4'h5, 16'h0000);
        write_reg(4'h6, 16'h090a);
        for (int k = 0; k < 3; k++)
        begin
            @(posedge mclk);
            pins <= pat[k];
            cmp <= k[0];
            repeat (4) @(posedge mclk);
            #1 p = pat[k];
            e = {4'h0, p[2], p[3], p[5], p[4], p[7], p[6], p[127], k[0],
                 p[8], 1'b0, p[9], p[10]};
            check({4'h0, periphIn}, e);
            check({4'h0, basicPeriphIn}, {6'h00, e[9:0]});
        end
    endtask : t_route

    task automatic t_timing;
        // pins hold the even-bit pattern here, so pin 12 is high
        write_reg(4'h5, 16'h000c);
        #1 check({15'h0, periphIn.spi2SelectN}, 16'h0000);
        @(posedge mclk);
        #1 check({15'h0, periphIn.spi2SelectN}, 16'h0001);
    endtask : t_timing

    task automatic results;
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results

    initial
    begin
        #200000;
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        results();
    end

    initial
    begin
        do_reset();
        t_zero();
        t_fields();
        t_route();
        t_timing();
        do_reset();
        t_zero();
        results();
    end
endmodule : input_pin_remap_selectors_tb_top
